// ---- tmr_pkg.sv ----
package tmr_pkg;

   // I/O register addresses
   localparam logic [5:0] ADDR_CTRL_A = 6'h00;
   localparam logic [5:0] ADDR_CTRL_B = 6'h01;
   localparam logic [5:0] ADDR_CNT_L  = 6'h02;
   localparam logic [5:0] ADDR_CNT_H  = 6'h03;
   localparam logic [5:0] ADDR_CMPA_L = 6'h04;
   localparam logic [5:0] ADDR_CMPA_H = 6'h05;
   localparam logic [5:0] ADDR_CMPB_L = 6'h06;
   localparam logic [5:0] ADDR_CMPB_H = 6'h07;
   localparam logic [5:0] ADDR_CAP_L  = 6'h08;
   localparam logic [5:0] ADDR_CAP_H  = 6'h09;
   localparam logic [5:0] ADDR_MASK   = 6'h0a;
   localparam logic [5:0] ADDR_FLAGS  = 6'h0b;

   // Field positions
   localparam int CB_NOISE   = 7;
   localparam int CB_EDGE    = 6;
   localparam int CB_RSVD    = 5;
   localparam int CB_WGM_HI  = 3;
   localparam int CA_FORCE_A = 3;
   localparam int CA_FORCE_B = 2;
   localparam int FLAG_CAP   = 5;
   localparam int FLAG_A     = 4;
   localparam int FLAG_B     = 3;
   localparam int FLAG_OVF   = 2;

   // Reset values and fixed figures
   localparam logic [7:0]  CTRL_RST    = 8'h00;
   localparam logic [15:0] WORD_RST    = 16'h0000;
   localparam logic [15:0] COUNT_MAX   = 16'hffff;
   localparam logic [15:0] TOP_8BIT    = 16'h00ff;
   localparam logic [15:0] TOP_9BIT    = 16'h01ff;
   localparam logic [15:0] TOP_10BIT   = 16'h03ff;
   localparam int          FILTER_LEN  = 4;
   localparam int          PRESC_W     = 10;

   // Clock select codes
   localparam logic [2:0] CS_STOP    = 3'h0;
   localparam logic [2:0] CS_DIV1    = 3'h1;
   localparam logic [2:0] CS_DIV8    = 3'h2;
   localparam logic [2:0] CS_DIV64   = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   typedef enum logic {TMR_UP, TMR_DOWN} tmr_dir_t;

endpackage

// ---- tmr_cap_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface tmr_cap_if;
   logic filter_en;
   logic edge_sel;
   logic enable;
   logic use_cmp;
   logic event_pulse;

   modport core (output filter_en, output edge_sel, output enable, output use_cmp, input event_pulse);
   modport cond (input filter_en, input edge_sel, input enable, input use_cmp, output event_pulse);
endinterface
`default_nettype wire

// ---- tmr_cap_cond.sv ----
`timescale 1ns/10ps
`default_nettype none
module tmr_cap_cond
   import tmr_pkg::*;
(
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic reset_in,
   // Raw trigger sources
   input  wire logic capture_pin_in,
   input  wire logic analog_cmp_in,
   // Core side
   tmr_cap_if.cond   cap
);

   logic [1:0]            pin_sync;
   logic [1:0]            cmp_sync;
   logic [FILTER_LEN-1:0] samples;
   logic                  filtered;
   logic                  level;
   logic                  level_d;
   logic                  src;

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         pin_sync <= 2'h0;
         cmp_sync <= 2'h0;
      end else begin
         pin_sync <= {pin_sync[0], capture_pin_in};
         cmp_sync <= {cmp_sync[0], analog_cmp_in};
      end
   end

   assign src = cap.use_cmp ? cmp_sync[1] : pin_sync[1];

   // Output moves only once the last samples all agree
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         samples  <= '0;
         filtered <= 1'b0;
      end else begin
         samples <= {samples[FILTER_LEN-2:0], src};
         if (&samples)
            filtered <= 1'b1;
         else if (~|samples)
            filtered <= 1'b0;
      end
   end

   assign level = cap.filter_en ? filtered : src;

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         level_d         <= 1'b0;
         cap.event_pulse <= 1'b0;
      end else begin
         level_d         <= level;
         cap.event_pulse <= cap.enable && (cap.edge_sel ? (level && !level_d) : (!level && level_d));
      end
   end

   property p_filter_agree;
      @(posedge clock_in) disable iff (reset_in)
      $changed(filtered) |-> ($past(samples) == {FILTER_LEN{filtered}});
   endproperty
   a_filter_agree: assert property (p_filter_agree) else $error("filter moved without agreeing samples");

   property p_edge_kind;
      @(posedge clock_in) disable iff (reset_in)
      cap.event_pulse |-> ($past(level) == $past(cap.edge_sel)) && ($past(level_d) != $past(cap.edge_sel));
   endproperty
   a_edge_kind: assert property (p_edge_kind) else $error("capture on wrong edge");

endmodule
`default_nettype wire

// ---- tmr_timer16.sv ----
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Filter on: capture input changes only after four equal samples.
// - Edge select zero triggers on falling edge, one on rising edge.
// - Capture copies counter into capture register and sets capture flag.
// - Capture register used as top disables pin captures.
// - Control B bit 5 reads zero; software writes it zero.
// - Clock select 000 stops; 001-101 divide I/O clock by 1..1024.
// - Codes 110/111 count falling/rising edges of external count pin.
// - External pin edges count even when pin is driven as output.
// - Sixteen-bit registers move through one shared high-byte holding register.
// - Counter write blocks compare matches on the next timer tick.
// - Both compare registers are compared with the counter continuously.
// - Request interrupt only when enable, global enable and flag are set.
// - Capture-as-top modes set capture flag when counter reaches top.
// - Flags clear on vector execution or when software writes one.
// - Compare flag sets in the timer tick following equality.
// - Forced compare strobes never set compare flags.
// - Overflow flag set point follows the waveform mode.
// - Capture source is the pin or the analog comparator output.
// - Four mode bits choose count sequence and top source.
module tmr_timer16
   import tmr_pkg::*;
(
   // Clock and reset
   input  wire logic       clock_in,
   input  wire logic       reset_in,
   // CPU I/O register port
   input  wire logic [5:0] io_addr_in,
   input  wire logic [7:0] io_wdata_in,
   input  wire logic       io_write_in,
   input  wire logic       io_read_in,
   output var  logic [7:0] io_rdata_out,
   // Interrupts
   input  wire logic       global_irq_en_in,
   input  wire logic [3:0] irq_ack_in,
   output var  logic [3:0] irq_req_out,
   // Pins
   input  wire logic       capture_pin_in,
   input  wire logic       analog_cmp_in,
   input  wire logic       capture_src_cmp_in,
   input  wire logic       external_count_pin_in,
   output var  logic [1:0] compare_wave_out
);

   logic [7:0]         timer_ctrl_a;
   logic [7:0]         timer_ctrl_b;
   logic [15:0]        counter_value;
   logic [15:0]        compare_a_value;
   logic [15:0]        compare_b_value;
   logic [15:0]        capture_value;
   logic [7:0]         timer_irq_mask;
   logic [7:0]         timer_irq_flags;
   logic [7:0]         next_flags;
   logic [7:0]         hold_byte;
   logic [7:0]         rd_mux;
   logic [PRESC_W-1:0] presc;
   logic [2:0]         ext_sync;
   logic               timer_tick;
   logic               match_block;
   logic [3:0]         mode;
   logic [15:0]        top;
   logic               cap_is_top;
   logic               cnt_wr;
   logic               wr_ctrl_a;
   logic               ovf_hit;
   logic               match_a;
   logic               match_b;
   logic [3:0]         set_vec;
   tmr_dir_t           dir;

   tmr_cap_if cap_bus ();

   tmr_cap_cond u_cap_cond (
      .clock_in       (clock_in),
      .reset_in       (reset_in),
      .capture_pin_in (capture_pin_in),
      .analog_cmp_in  (analog_cmp_in),
      .cap            (cap_bus.cond)
   );

   function automatic logic is_high(input logic [5:0] a);
      return (a == ADDR_CNT_H) || (a == ADDR_CMPA_H) || (a == ADDR_CMPB_H) || (a == ADDR_CAP_H);
   endfunction

   function automatic logic is_low(input logic [5:0] a);
      return (a == ADDR_CNT_L) || (a == ADDR_CMPA_L) || (a == ADDR_CMPB_L) || (a == ADDR_CAP_L);
   endfunction

   function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ca, input logic [15:0] ic);
      case (m)
         4'h1, 4'h5:                top_of = TOP_8BIT;
         4'h2, 4'h6:                top_of = TOP_9BIT;
         4'h3, 4'h7:                top_of = TOP_10BIT;
         4'h4, 4'h9, 4'hb, 4'hf:    top_of = ca;
         4'h8, 4'ha, 4'hc, 4'he:    top_of = ic;
         default:                   top_of = COUNT_MAX;
      endcase
   endfunction

   function automatic logic dual_slope(input logic [3:0] m);
      return (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
   endfunction

   function automatic logic non_pwm(input logic [3:0] m);
      return (m == 4'h0) || (m == 4'h4) || (m == 4'hc);
   endfunction

   // Mode and top decode
   assign mode       = {timer_ctrl_b[CB_WGM_HI+1:CB_WGM_HI], timer_ctrl_a[1:0]};
   assign top        = top_of(mode, compare_a_value, capture_value);
   assign cap_is_top = (mode == 4'h8) || (mode == 4'ha) || (mode == 4'hc) || (mode == 4'he);
   assign cnt_wr     = io_write_in && (io_addr_in == ADDR_CNT_L);
   assign wr_ctrl_a  = io_write_in && (io_addr_in == ADDR_CTRL_A);

   assign cap_bus.filter_en = timer_ctrl_b[CB_NOISE];
   assign cap_bus.edge_sel  = timer_ctrl_b[CB_EDGE];
   assign cap_bus.enable    = !cap_is_top;
   assign cap_bus.use_cmp   = capture_src_cmp_in;

   // Prescaler runs freely; taps give the slower ticks
   always_ff @(posedge clock_in) begin
      if (reset_in)
         presc <= '0;
      else
         presc <= presc + 1'b1;
   end

   // Pin is read through the synchroniser whatever its port direction
   always_ff @(posedge clock_in) begin
      if (reset_in)
         ext_sync <= 3'h0;
      else
         ext_sync <= {ext_sync[1:0], external_count_pin_in};
   end

   always_comb begin
      case (timer_ctrl_b[2:0])
         CS_DIV1:     timer_tick = 1'b1;
         CS_DIV8:     timer_tick = &presc[2:0];
         CS_DIV64:    timer_tick = &presc[5:0];
         CS_DIV256:   timer_tick = &presc[7:0];
         CS_DIV1024:  timer_tick = &presc[9:0];
         CS_EXT_FALL: timer_tick = !ext_sync[1] && ext_sync[2];
         CS_EXT_RISE: timer_tick = ext_sync[1] && !ext_sync[2];
         default:     timer_tick = 1'b0;
      endcase
   end

   // Control registers
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         timer_ctrl_a <= CTRL_RST;
         timer_ctrl_b <= CTRL_RST;
      end else if (io_write_in) begin
         // Force strobes are not stored, so they read back as zero
         if (io_addr_in == ADDR_CTRL_A)
            timer_ctrl_a <= io_wdata_in & 8'hf3;
         if (io_addr_in == ADDR_CTRL_B)
            timer_ctrl_b <= io_wdata_in & ~(8'h01 << CB_RSVD);
      end
   end

   // Shared high-byte holding register
   always_ff @(posedge clock_in) begin
      if (reset_in)
         hold_byte <= 8'h00;
      else if (io_write_in && is_high(io_addr_in))
         hold_byte <= io_wdata_in;
      else if (io_read_in && is_low(io_addr_in)) begin
         case (io_addr_in)
            ADDR_CNT_L:  hold_byte <= counter_value[15:8];
            ADDR_CMPA_L: hold_byte <= compare_a_value[15:8];
            ADDR_CMPB_L: hold_byte <= compare_b_value[15:8];
            default:     hold_byte <= capture_value[15:8];
         endcase
      end
   end

   // Counter; a CPU write wins over counting
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         counter_value <= WORD_RST;
         dir           <= TMR_UP;
      end else if (cnt_wr) begin
         counter_value <= {hold_byte, io_wdata_in};
      end else if (timer_tick) begin
         case (dir)
            TMR_UP: begin
               if (counter_value == top && dual_slope(mode)) begin
                  counter_value <= counter_value - 1'b1;
                  dir           <= TMR_DOWN;
               end else if (counter_value == top)
                  counter_value <= WORD_RST;
               else
                  counter_value <= counter_value + 1'b1;
            end
            TMR_DOWN: begin
               if (counter_value == WORD_RST || !dual_slope(mode)) begin
                  counter_value <= counter_value + 1'b1;
                  dir           <= TMR_UP;
               end else
                  counter_value <= counter_value - 1'b1;
            end
            default: dir <= TMR_UP;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in)
         match_block <= 1'b0;
      else if (cnt_wr)
         match_block <= 1'b1;
      else if (timer_tick)
         match_block <= 1'b0;
   end

   // Compare and capture registers; capture wins over a CPU write
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         compare_a_value <= WORD_RST;
         compare_b_value <= WORD_RST;
         capture_value   <= WORD_RST;
      end else begin
         if (io_write_in && io_addr_in == ADDR_CMPA_L)
            compare_a_value <= {hold_byte, io_wdata_in};
         if (io_write_in && io_addr_in == ADDR_CMPB_L)
            compare_b_value <= {hold_byte, io_wdata_in};
         if (cap_bus.event_pulse && !cap_is_top)
            capture_value <= counter_value;
         else if (io_write_in && io_addr_in == ADDR_CAP_L)
            capture_value <= {hold_byte, io_wdata_in};
      end
   end

   // Matches are evaluated on the tick that leaves the equal value
   assign match_a = timer_tick && !match_block && (counter_value == compare_a_value);
   assign match_b = timer_tick && !match_block && (counter_value == compare_b_value);

   always_comb begin
      if (dual_slope(mode))
         ovf_hit = (dir == TMR_DOWN) && (counter_value == WORD_RST);
      else if (non_pwm(mode))
         ovf_hit = (counter_value == COUNT_MAX);
      else
         ovf_hit = (counter_value == top);
   end

   assign set_vec[3] = cap_is_top ? (timer_tick && counter_value == top) : cap_bus.event_pulse;
   assign set_vec[2] = match_a;
   assign set_vec[1] = match_b;
   assign set_vec[0] = timer_tick && ovf_hit;

   // Clears first, then sets, so a simultaneous event is kept
   always_comb begin
      next_flags = timer_irq_flags;
      if (io_write_in && io_addr_in == ADDR_FLAGS)
         next_flags[FLAG_CAP:FLAG_OVF] = next_flags[FLAG_CAP:FLAG_OVF] & ~io_wdata_in[FLAG_CAP:FLAG_OVF];
      next_flags[FLAG_CAP:FLAG_OVF] = next_flags[FLAG_CAP:FLAG_OVF] & ~irq_ack_in;
      next_flags[FLAG_CAP:FLAG_OVF] = next_flags[FLAG_CAP:FLAG_OVF] | set_vec;
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         timer_irq_flags <= CTRL_RST;
         timer_irq_mask  <= CTRL_RST;
      end else begin
         timer_irq_flags <= next_flags;
         if (io_write_in && io_addr_in == ADDR_MASK)
            timer_irq_mask <= io_wdata_in & 8'h3c;
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in)
         irq_req_out <= 4'h0;
      else
         irq_req_out <= timer_irq_flags[FLAG_CAP:FLAG_OVF] & timer_irq_mask[FLAG_CAP:FLAG_OVF]
                        & {4{global_irq_en_in}};
   end

   // Toggling stands in for the pin modes handled elsewhere
   always_ff @(posedge clock_in) begin
      if (reset_in)
         compare_wave_out <= 2'h0;
      else begin
         if (match_a || (wr_ctrl_a && non_pwm(mode) && io_wdata_in[CA_FORCE_A]))
            compare_wave_out[0] <= !compare_wave_out[0];
         if (match_b || (wr_ctrl_a && non_pwm(mode) && io_wdata_in[CA_FORCE_B]))
            compare_wave_out[1] <= !compare_wave_out[1];
      end
   end

   always_comb begin
      case (io_addr_in)
         ADDR_CTRL_A: rd_mux = timer_ctrl_a;
         ADDR_CTRL_B: rd_mux = timer_ctrl_b;
         ADDR_CNT_L:  rd_mux = counter_value[7:0];
         ADDR_CMPA_L: rd_mux = compare_a_value[7:0];
         ADDR_CMPB_L: rd_mux = compare_b_value[7:0];
         ADDR_CAP_L:  rd_mux = capture_value[7:0];
         ADDR_CNT_H, ADDR_CMPA_H, ADDR_CMPB_H, ADDR_CAP_H: rd_mux = hold_byte;
         ADDR_MASK:   rd_mux = timer_irq_mask;
         ADDR_FLAGS:  rd_mux = timer_irq_flags;
         default:     rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (reset_in)
         io_rdata_out <= 8'h00;
      else if (io_read_in)
         io_rdata_out <= rd_mux;
   end

   // Checks
   property p_capture_copy;
      @(posedge clock_in) disable iff (reset_in)
      cap_bus.event_pulse && !cap_is_top |=> (capture_value == $past(counter_value)) && timer_irq_flags[FLAG_CAP];
   endproperty
   a_capture_copy: assert property (p_capture_copy) else $error("capture did not copy counter");

   property p_no_capture_top;
      @(posedge clock_in) disable iff (reset_in)
      cap_is_top && !(io_write_in && io_addr_in == ADDR_CAP_L) |=> $stable(capture_value);
   endproperty
   a_no_capture_top: assert property (p_no_capture_top) else $error("capture while used as top");

   property p_rsvd_zero;
      @(posedge clock_in) disable iff (reset_in)
      io_read_in && io_addr_in == ADDR_CTRL_B |=> !io_rdata_out[CB_RSVD];
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

   property p_stopped;
      @(posedge clock_in) disable iff (reset_in)
      timer_ctrl_b[2:0] == CS_STOP && !cnt_wr |=> $stable(counter_value);
   endproperty
   a_stopped: assert property (p_stopped) else $error("stopped counter moved");

   property p_block;
      @(posedge clock_in) disable iff (reset_in)
      cnt_wr ##1 (timer_tick && !timer_irq_flags[FLAG_A] && irq_ack_in == 4'h0) |=> !timer_irq_flags[FLAG_A];
   endproperty
   a_block: assert property (p_block) else $error("match after counter write");

   property p_irq_gate;
      @(posedge clock_in) disable iff (reset_in)
      !global_irq_en_in || timer_irq_mask[FLAG_OVF:FLAG_OVF] == 1'b0 |=> !irq_req_out[0];
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("overflow request without enables");

   property p_irq_raise;
      @(posedge clock_in) disable iff (reset_in)
      global_irq_en_in && timer_irq_mask[FLAG_A] && timer_irq_flags[FLAG_A] |=> irq_req_out[2];
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("compare A request missing");

   property p_ack_clear;
      @(posedge clock_in) disable iff (reset_in)
      irq_ack_in[0] && !timer_tick |=> !timer_irq_flags[FLAG_OVF];
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear overflow flag");

   property p_match_flag;
      @(posedge clock_in) disable iff (reset_in)
      timer_tick && !match_block && counter_value == compare_b_value |=> timer_irq_flags[FLAG_B];
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("compare B flag not set");

   property p_force_no_flag;
      @(posedge clock_in) disable iff (reset_in)
      wr_ctrl_a && io_wdata_in[CA_FORCE_A] && !match_a && !timer_irq_flags[FLAG_A] |=> !timer_irq_flags[FLAG_A];
   endproperty
   a_force_no_flag: assert property (p_force_no_flag) else $error("force set compare flag");

   property p_zero_write_keeps;
      @(posedge clock_in) disable iff (reset_in)
      io_write_in && io_addr_in == ADDR_FLAGS && !io_wdata_in[FLAG_CAP] && irq_ack_in[3] == 1'b0
         && timer_irq_flags[FLAG_CAP] |=> timer_irq_flags[FLAG_CAP];
   endproperty
   a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("zero write cleared flag");

   c_capture: cover property (@(posedge clock_in) disable iff (reset_in) cap_bus.event_pulse);
   c_overflow: cover property (@(posedge clock_in) disable iff (reset_in) set_vec[0]);
   c_dual_turn: cover property (@(posedge clock_in) disable iff (reset_in) dir == TMR_DOWN ##1 dir == TMR_UP);

endmodule
`default_nettype wire

// ---- tmr_cpu_vec.sv ----
`timescale 1ns/10ps
`default_nettype none
module tmr_cpu_vec (
   // Clock and reset
   input  wire logic       clock_in,
   input  wire logic       reset_in,
   // Interrupt lines
   input  wire logic [3:0] irq_req_in,
   output var  logic [3:0] irq_ack_out
);
   logic [1:0] busy;

   // One vector at a time, capture first; the pause lets a served request drop
   always_ff @(posedge clock_in) begin
      irq_ack_out <= 4'h0;
      if (reset_in) begin
         busy <= 2'h0;
      end else if (busy != 2'h0) begin
         busy <= busy - 2'h1;
      end else if (irq_req_in != 4'h0) begin
         busy <= 2'h3;
         irq_ack_out <= irq_req_in[3] ? 4'h8 : irq_req_in[2] ? 4'h4 : irq_req_in[1] ? 4'h2 : 4'h1;
      end
   end
endmodule
`default_nettype wire

// ---- tb_timer16_capture_compare_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_timer16_capture_compare_regs
   import tmr_pkg::*;
();
   logic       clock_in = 1'b0;
   logic       reset_in = 1'b1;
   logic [5:0] addr     = 6'h00;
   logic [7:0] wdata    = 8'h00;
   logic       wr_en    = 1'b0;
   logic       rd_en    = 1'b0;
   logic       gie      = 1'b0;
   logic       cap_pin  = 1'b0;
   logic       ext_pin  = 1'b0;
   logic       cmp_out  = 1'b0;
   logic       cmp_sel  = 1'b0;
   logic [7:0] rdata;
   logic [3:0] ack;
   logic [3:0] irq;
   logic [1:0] wave;
   int         num_errors = 0;
   int         tests_run  = 0;
   int         cycles     = 0;

   always #5 clock_in = ~clock_in;

   tmr_timer16 u_dut (.clock_in(clock_in), .reset_in(reset_in), .io_addr_in(addr), .io_wdata_in(wdata),
      .io_write_in(wr_en), .io_read_in(rd_en), .io_rdata_out(rdata), .global_irq_en_in(gie),
      .irq_ack_in(ack), .irq_req_out(irq), .capture_pin_in(cap_pin), .analog_cmp_in(cmp_out),
      .capture_src_cmp_in(cmp_sel), .external_count_pin_in(ext_pin), .compare_wave_out(wave));

   tmr_cpu_vec u_cpu (.clock_in(clock_in), .reset_in(reset_in), .irq_req_in(irq), .irq_ack_out(ack));

   task automatic test_done;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Longest scenario is the divide-by-1024 run, well under this ceiling
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge clock_in);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge clock_in);
      wr_en = 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(negedge clock_in);
      addr = a;
      rd_en = 1'b1;
      @(negedge clock_in);
      rd_en = 1'b0;
      d = rdata;
   endtask

   // High byte first on writes, low byte first on reads
   task automatic wr16(input logic [5:0] a, input logic [15:0] w);
      wr(a + 6'h01, w[15:8]);
      wr(a, w[7:0]);
   endtask

   task automatic rd16(input logic [5:0] a, output logic [15:0] w);
      rd(a, w[7:0]);
      rd(a + 6'h01, w[15:8]);
   endtask

   task automatic t_reset;
      logic [5:0] ra[5] = '{ADDR_CTRL_B, ADDR_MASK, ADDR_FLAGS, ADDR_CMPA_L, 6'h0c};
      logic [7:0] d;
      foreach (ra[i]) begin
         rd(ra[i], d);
         check("reset_read", {8'h00, d}, 16'h0000);
      end
   endtask

   task automatic t_match_irq;
      logic [7:0] d;
      wr(ADDR_MASK, 8'h14);
      wr16(ADDR_CMPA_L, 16'hfff8);
      wr16(ADDR_CMPB_L, 16'h0000);
      wr16(ADDR_CNT_L, 16'hfff0);
      wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
      repeat (30) @(negedge clock_in);
      wr(ADDR_CTRL_B, 8'h00);
      check("irq_gie_off", {12'h000, irq}, 16'h0000);
      wr(ADDR_FLAGS, 8'h00);
      rd(ADDR_FLAGS, d);
      check("flags_match", {8'h00, d}, 16'h001c);
      gie = 1'b1;
      for (int i = 0; i < 10 && irq === 4'h0; i++) @(negedge clock_in);
      check("irq_req", {12'h000, irq}, 16'h0005);
      repeat (20) @(negedge clock_in);
      rd(ADDR_FLAGS, d);
      check("flags_acked", {8'h00, d}, 16'h0008);
      wr(ADDR_FLAGS, 8'h08);
      rd(ADDR_FLAGS, d);
      check("flags_w1c", {8'h00, d}, 16'h0000);
      gie = 1'b0;
   endtask

   // One match on each channel above, so both outputs stand toggled
   task automatic t_force;
      logic [7:0] d;
      check("wave_matches", {14'h0000, wave}, 16'h0003);
      wr(ADDR_CTRL_A, 8'h08);
      wr(ADDR_CTRL_A, 8'h04);
      check("wave_forced", {14'h0000, wave}, 16'h0000);
      rd(ADDR_FLAGS, d);
      check("force_no_flag", {8'h00, d}, 16'h0000);
   endtask

   task automatic t_top_modes;
      logic [15:0] w;
      logic [7:0]  d;
      wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
      wr16(ADDR_CNT_L, 16'h0000);
      wr(ADDR_CTRL_B, 8'h00);
      rd(ADDR_FLAGS, d);
      check("write_blocks_match", {8'h00, d}, 16'h0000);
      wr16(ADDR_CNT_L, 16'h0000);
      wr16(ADDR_CAP_L, 16'h0010);
      wr(ADDR_CTRL_B, {3'h0, 2'h3, CS_DIV1});
      cap_pin = 1'b0;
      repeat (30) @(negedge clock_in);
      wr(ADDR_CTRL_B, 8'h00);
      rd16(ADDR_CAP_L, w);
      check("top_no_capture", w, 16'h0010);
      rd(ADDR_FLAGS, d);
      check("top_cap_flag", {8'h00, d}, 16'h0028);
      check("wave_match_b", {14'h0000, wave}, 16'h0002);
      wr(ADDR_FLAGS, 8'h28);
   endtask

   task automatic t_capture;
      logic [15:0] w;
      logic [7:0]  d;
      wr(ADDR_CTRL_B, 8'h40);
      wr16(ADDR_CNT_L, 16'h0abc);
      cap_pin = 1'b1;
      repeat (10) @(negedge clock_in);
      rd16(ADDR_CAP_L, w);
      check("capture", w, 16'h0abc);
      rd(ADDR_FLAGS, d);
      check("cap_flag", {8'h00, d}, 16'h0020);
      wr(ADDR_FLAGS, 8'h20);
      wr(ADDR_CTRL_B, 8'hc0);
      wr16(ADDR_CNT_L, 16'h0055);
      cap_pin = 1'b0;
      repeat (10) @(negedge clock_in);
      cap_pin = 1'b1;
      repeat (2) @(negedge clock_in);
      cap_pin = 1'b0;
      repeat (10) @(negedge clock_in);
      rd(ADDR_FLAGS, d);
      check("no_capture", {8'h00, d}, 16'h0000);
      cap_pin = 1'b1;
      repeat (12) @(negedge clock_in);
      rd16(ADDR_CAP_L, w);
      check("filtered_capture", w, 16'h0055);
      wr(ADDR_FLAGS, 8'h20);
      wr16(ADDR_CNT_L, 16'h0123);
      cmp_sel = 1'b1;
      repeat (10) @(negedge clock_in);
      cmp_out = 1'b1;
      repeat (12) @(negedge clock_in);
      rd16(ADDR_CAP_L, w);
      check("comparator_capture", w, 16'h0123);
      wr(ADDR_FLAGS, 8'h20);
      cmp_sel = 1'b0;
   endtask

   task automatic t_clock_select;
      int          div[5] = '{1, 8, 64, 256, 1024};
      logic [15:0] w;
      for (int i = 0; i < 5; i++) begin
         wr16(ADDR_CNT_L, 16'h0000);
         wr(ADDR_CTRL_B, 8'(i + 1));
         repeat (20 * div[i]) @(negedge clock_in);
         wr(ADDR_CTRL_B, 8'h00);
         rd16(ADDR_CNT_L, w);
         check("prescaled_count", {15'h0000, (w - 16'h0013) <= 16'h0005}, 16'h0001);
         rd16(ADDR_CNT_L, w);
         check("stopped_count", {15'h0000, (w - 16'h0013) <= 16'h0005}, 16'h0001);
      end
      for (int c = 6; c < 8; c++) begin
         wr16(ADDR_CNT_L, 16'h0000);
         wr(ADDR_CTRL_B, 8'(c));
         repeat (3) begin
            ext_pin = 1'b1;
            repeat (4) @(negedge clock_in);
            ext_pin = 1'b0;
            repeat (4) @(negedge clock_in);
         end
         wr(ADDR_CTRL_B, 8'h00);
         rd16(ADDR_CNT_L, w);
         check("external_count", w, 16'h0003);
      end
   endtask

   initial begin
      repeat (6) @(negedge clock_in);
      reset_in = 1'b0;
      t_reset();
      t_match_irq();
      t_force();
      t_capture();
      t_top_modes();
      t_clock_select();
      test_done();
   end
endmodule
`default_nettype wire
